// *** dgct_top.sv ***
// dgct_top: dual 13-bit gated counter/timer with apb register access.
// assumes: apb master on sys_clk; pins synchronous to sys_clk.
module dgct_top #(
  parameter int DIV0 = dgct_pkg::DIV_SCALE0,
  parameter int DIV1 = dgct_pkg::DIV_SCALE1,
  parameter int DIV2 = dgct_pkg::DIV_SCALE2,
  parameter int DIV3 = dgct_pkg::DIV_EXT
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // event and gate pins
  input  wire logic        event_pin_a,
  input  wire logic        event_pin_b,
  input  wire logic        gate_input_a,
  input  wire logic        gate_input_b,
  input  wire logic        ext_osc_tick,
  // interrupt request and acknowledge
  output logic             irq_req_a,
  output logic             irq_req_b,
  input  wire logic        irq_ack_a,
  input  wire logic        irq_ack_b
);

  // control state
  logic        timer_a_run_bit;
  logic        timer_b_run_bit;
  logic        timer_a_overflow_flag;
  logic        timer_b_overflow_flag;
  logic [7:0]  timer_mode_reg;
  logic [1:0]  prescale_select_field;
  logic        timer_a_sysclk_select;
  logic        timer_b_sysclk_select;
  logic        gate_a_polarity;
  logic        gate_b_polarity;
  logic        timer_a_irq_enable;
  logic        timer_b_irq_enable;
  logic [31:0] prdata_reg;
  logic        presc_tick;
  logic [7:0]  timer_a_low_byte;
  logic [7:0]  timer_a_high_byte;
  logic [7:0]  timer_b_low_byte;
  logic [7:0]  timer_b_high_byte;
  logic        ovf_a;
  logic        ovf_b;

  // address decode and strobes
  wire hit_ctrl  = (paddr == dgct_pkg::OFS_CONTROL);
  wire hit_mode  = (paddr == dgct_pkg::OFS_MODE);
  wire hit_clk   = (paddr == dgct_pkg::OFS_CLOCK);
  wire hit_ext   = (paddr == dgct_pkg::OFS_EXTCFG);
  wire hit_ien   = (paddr == dgct_pkg::OFS_IRQ_EN);
  wire hit_a_lo  = (paddr == dgct_pkg::OFS_A_LOW);
  wire hit_a_hi  = (paddr == dgct_pkg::OFS_A_HIGH);
  wire hit_b_lo  = (paddr == dgct_pkg::OFS_B_LOW);
  wire hit_b_hi  = (paddr == dgct_pkg::OFS_B_HIGH);
  wire addr_hit  = hit_ctrl | hit_mode | hit_clk | hit_ext | hit_ien |
                   hit_a_lo | hit_a_hi | hit_b_lo | hit_b_hi;
  wire access    = psel && penable;
  wire setup     = psel && !penable;
  wire wr_en     = access && pwrite && addr_hit;
  wire wr_ctrl   = wr_en && hit_ctrl;
  wire wr_a_lo   = wr_en && hit_a_lo;
  wire wr_a_hi   = wr_en && hit_a_hi;
  wire wr_b_lo   = wr_en && hit_b_lo;
  wire wr_b_hi   = wr_en && hit_b_hi;

  // gating: run bit and, when selected, the gate pin at its active level
  wire timer_a_gate_select = timer_mode_reg[dgct_pkg::BIT_GATE_SEL];
  wire timer_b_gate_select = timer_mode_reg[dgct_pkg::MODE_B_OFS + dgct_pkg::BIT_GATE_SEL];
  wire gate_active_a = (gate_input_a == gate_a_polarity);
  wire gate_active_b = (gate_input_b == gate_b_polarity);
  wire enable_a = timer_a_run_bit && (!timer_a_gate_select || gate_active_a);
  wire enable_b = timer_b_run_bit && (!timer_b_gate_select || gate_active_b);

  // read data mux
  wire [7:0] ctrl_rd = {timer_b_overflow_flag, timer_b_run_bit,
                        timer_a_overflow_flag, timer_a_run_bit, 4'h0};
  wire [7:0] clk_rd  = {3'h0, timer_b_sysclk_select, timer_a_sysclk_select,
                        1'b0, prescale_select_field};
  wire [7:0] ext_rd  = {gate_b_polarity, 3'h0, gate_a_polarity, 3'h0};
  wire [7:0] ien_rd  = {4'h0, timer_b_irq_enable, 1'b0, timer_a_irq_enable, 1'b0};
  wire [7:0] rd_byte = hit_ctrl ? ctrl_rd :
                       hit_mode ? timer_mode_reg :
                       hit_clk  ? clk_rd :
                       hit_ext  ? ext_rd :
                       hit_ien  ? ien_rd :
                       hit_a_lo ? timer_a_low_byte :
                       hit_a_hi ? timer_a_high_byte :
                       hit_b_lo ? timer_b_low_byte :
                       hit_b_hi ? timer_b_high_byte : dgct_pkg::RESET_BYTE;

  // overflow flags: hardware set wins over software clear or acknowledge
  wire flag_a_next = ovf_a ||
                     (wr_ctrl ? pwdata[dgct_pkg::BIT_FLAG_A] :
                      (irq_ack_a ? 1'b0 : timer_a_overflow_flag));
  wire flag_b_next = ovf_b ||
                     (wr_ctrl ? pwdata[dgct_pkg::BIT_FLAG_B] :
                      (irq_ack_b ? 1'b0 : timer_b_overflow_flag));

  // control registers; run bits touch only run state, never the count
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_a_run_bit       <= 1'b0;
      timer_b_run_bit       <= 1'b0;
      timer_a_overflow_flag <= 1'b0;
      timer_b_overflow_flag <= 1'b0;
      timer_mode_reg        <= dgct_pkg::RESET_BYTE;
      prescale_select_field <= 2'b00;
      timer_a_sysclk_select <= 1'b0;
      timer_b_sysclk_select <= 1'b0;
      gate_a_polarity       <= 1'b0;
      gate_b_polarity       <= 1'b0;
      timer_a_irq_enable    <= 1'b0;
      timer_b_irq_enable    <= 1'b0;
    end else begin
      timer_a_overflow_flag <= flag_a_next;
      timer_b_overflow_flag <= flag_b_next;
      if (wr_ctrl) begin
        timer_a_run_bit <= pwdata[dgct_pkg::BIT_RUN_A];
        timer_b_run_bit <= pwdata[dgct_pkg::BIT_RUN_B];
      end
      if (wr_en && hit_mode) begin
        timer_mode_reg <= pwdata[7:0];
      end
      if (wr_en && hit_clk) begin
        prescale_select_field <= pwdata[1:0];
        timer_a_sysclk_select <= pwdata[dgct_pkg::BIT_SYSCLK_A];
        timer_b_sysclk_select <= pwdata[dgct_pkg::BIT_SYSCLK_B];
      end
      if (wr_en && hit_ext) begin
        gate_a_polarity <= pwdata[dgct_pkg::BIT_POL_A];
        gate_b_polarity <= pwdata[dgct_pkg::BIT_POL_B];
      end
      if (wr_en && hit_ien) begin
        timer_a_irq_enable <= pwdata[dgct_pkg::BIT_IRQ_EN_A];
        timer_b_irq_enable <= pwdata[dgct_pkg::BIT_IRQ_EN_B];
      end
    end
  end

  // read data captured in the setup cycle, presented in the access cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg <= dgct_pkg::READ_ZERO;
    end else if (setup) begin
      prdata_reg <= {24'h000000, rd_byte};
    end
  end

  // apb answer: zero wait states, error on unmapped address
  assign prdata    = prdata_reg;
  assign pready    = 1'b1;
  assign pslverr   = access && !addr_hit;
  assign irq_req_a = timer_a_overflow_flag && timer_a_irq_enable;
  assign irq_req_b = timer_b_overflow_flag && timer_b_irq_enable;

  dgct_prescaler #(
    .DIV0 (DIV0),
    .DIV1 (DIV1),
    .DIV2 (DIV2),
    .DIV3 (DIV3)
  ) u_presc (
    .sys_clk               (sys_clk),
    .reset_n               (reset_n),
    .prescale_select_field (prescale_select_field),
    .ext_osc_tick          (ext_osc_tick),
    .presc_tick            (presc_tick)
  );

  dgct_timer_unit u_timer_a (
    .sys_clk             (sys_clk),
    .reset_n             (reset_n),
    .mode                (timer_mode_reg[1:0]),
    .count_source_select (timer_mode_reg[dgct_pkg::BIT_SRC_SEL]),
    .sysclk_select       (timer_a_sysclk_select),
    .count_enable        (enable_a),
    .presc_tick          (presc_tick),
    .event_pin           (event_pin_a),
    .wr_low              (wr_a_lo),
    .wr_high             (wr_a_hi),
    .wr_data             (pwdata[7:0]),
    .low_byte            (timer_a_low_byte),
    .high_byte           (timer_a_high_byte),
    .overflow            (ovf_a)
  );

  dgct_timer_unit u_timer_b (
    .sys_clk             (sys_clk),
    .reset_n             (reset_n),
    .mode                (timer_mode_reg[dgct_pkg::MODE_B_OFS +: 2]),
    .count_source_select (timer_mode_reg[dgct_pkg::MODE_B_OFS + dgct_pkg::BIT_SRC_SEL]),
    .sysclk_select       (timer_b_sysclk_select),
    .count_enable        (enable_b),
    .presc_tick          (presc_tick),
    .event_pin           (event_pin_b),
    .wr_low              (wr_b_lo),
    .wr_high             (wr_b_hi),
    .wr_data             (pwdata[7:0]),
    .low_byte            (timer_b_low_byte),
    .high_byte           (timer_b_high_byte),
    .overflow            (ovf_b)
  );

  // checks on flags, gating and bus answers
  wire [15:0] cnt_a   = {timer_a_high_byte, timer_a_low_byte};
  wire        wr_a_any = wr_a_lo || wr_a_hi;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_flag_set: assert property (ovf_a |=> timer_a_overflow_flag)
    else $error("overflow did not set flag a");
  a_flag_b_set: assert property (ovf_b |=> timer_b_overflow_flag)
    else $error("overflow did not set flag b");
  a_flag_sticky: assert property (
    timer_a_overflow_flag && !irq_ack_a && !wr_ctrl |=> timer_a_overflow_flag)
    else $error("flag a dropped without clear");
  a_rollover_zero: assert property (
    ovf_a && (timer_mode_reg[1:0] == dgct_pkg::DGCT_MODE_13BIT) && !wr_a_any
    |=> {timer_a_high_byte, timer_a_low_byte[4:0]} == 13'h0000)
    else $error("13-bit count did not wrap to zero");
  a_irq_masked: assert property (
    !timer_a_irq_enable |-> !irq_req_a)
    else $error("masked timer a requested interrupt");
  a_irq_raised: assert property (
    ovf_b && timer_b_irq_enable && !wr_en |=> irq_req_b)
    else $error("enabled timer b overflow gave no request");
  a_stop_hold: assert property (!timer_a_run_bit && !wr_a_any |=> $stable(cnt_a))
    else $error("stopped timer a moved");
  a_gate_hold: assert property (
    timer_a_gate_select && !gate_active_a && !wr_a_any |=> $stable(cnt_a))
    else $error("gated-off timer a moved");
  a_run_keeps: assert property (
    wr_ctrl && pwdata[dgct_pkg::BIT_RUN_A] && !timer_a_run_bit && !wr_a_any
    |=> $stable(cnt_a))
    else $error("starting timer a changed count");
  a_apb_answer: assert property (access |-> pready && (pslverr == !addr_hit))
    else $error("apb answer wrong");

  c_ovf_a: cover property (ovf_a ##1 timer_a_overflow_flag);
  c_gate_block: cover property (timer_a_run_bit && timer_a_gate_select && !gate_active_a);
  c_irq_b: cover property (irq_req_b);
  c_ack_clear: cover property (timer_a_overflow_flag && irq_ack_a ##1 !timer_a_overflow_flag);

endmodule

// *** dgct_pkg.sv ***
// dgct_pkg: register map, field positions, reset values, modes and
// count helpers for the dual 13-bit gated counter/timer.
// assumes: 32-bit apb data, one aligned word per register.
package dgct_pkg;

  // register byte addresses
  localparam logic [7:0] OFS_CONTROL   = 8'h00; // timer_control_reg
  localparam logic [7:0] OFS_MODE      = 8'h04; // timer_mode_reg
  localparam logic [7:0] OFS_CLOCK     = 8'h08; // clock_control_reg
  localparam logic [7:0] OFS_EXTCFG    = 8'h0c; // ext_input_config_reg
  localparam logic [7:0] OFS_IRQ_EN    = 8'h10; // interrupt_enable_reg
  localparam logic [7:0] OFS_A_LOW     = 8'h14;
  localparam logic [7:0] OFS_A_HIGH    = 8'h18;
  localparam logic [7:0] OFS_B_LOW     = 8'h1c;
  localparam logic [7:0] OFS_B_HIGH    = 8'h20;

  // timer_control_reg bits
  localparam int BIT_FLAG_B = 7;
  localparam int BIT_RUN_B  = 6;
  localparam int BIT_FLAG_A = 5;
  localparam int BIT_RUN_A  = 4;
  // timer_mode_reg: timer a in bits 3:0, timer b in bits 7:4
  localparam int MODE_B_OFS   = 4;
  localparam int BIT_SRC_SEL  = 2; // count source select within nibble
  localparam int BIT_GATE_SEL = 3; // gate select within nibble
  // clock_control_reg bits
  localparam int BIT_SYSCLK_A = 3;
  localparam int BIT_SYSCLK_B = 4;
  // ext_input_config_reg bits
  localparam int BIT_POL_A = 3;
  localparam int BIT_POL_B = 7;
  // interrupt_enable_reg bits
  localparam int BIT_IRQ_EN_A = 1;
  localparam int BIT_IRQ_EN_B = 3;

  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  localparam logic [15:0] RESET_COUNT = 16'h0000;
  localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

  // prescale divisor defaults (scale 0..2 on sys_clk, 3 on external ticks)
  localparam int DIV_SCALE0 = 12;
  localparam int DIV_SCALE1 = 4;
  localparam int DIV_SCALE2 = 48;
  localparam int DIV_EXT    = 8;

  typedef enum logic [1:0] {
    DGCT_MODE_13BIT  = 2'b00,
    DGCT_MODE_16BIT  = 2'b01,
    DGCT_MODE_RELOAD = 2'b10,
    DGCT_MODE_SPLIT  = 2'b11
  } dgct_mode_e;

  localparam logic [12:0] MAX13 = 13'h1fff;
  localparam logic [15:0] MAX16 = 16'hffff;

  // next count value for one step in the given mode
  function automatic logic [15:0] next_count(input logic [1:0] mode, input logic [15:0] c);
    logic [12:0] v;
    v = {c[15:8], c[4:0]} + 13'h0001;
    if (mode == DGCT_MODE_13BIT) begin
      next_count = {v[12:5], c[7:5], v[4:0]};
    end else begin
      next_count = c + 16'h0001;
    end
  endfunction

  // count is at its top value for the given mode
  function automatic logic at_top(input logic [1:0] mode, input logic [15:0] c);
    if (mode == DGCT_MODE_13BIT) begin
      at_top = ({c[15:8], c[4:0]} == MAX13);
    end else begin
      at_top = (c == MAX16);
    end
  endfunction

endpackage

// *** dgct_prescaler.sv ***
// dgct_prescaler: shared prescaled clock tick for both timers.
// assumes: ext_osc_tick is a one-cycle pulse synchronous to sys_clk.
module dgct_prescaler #(
  parameter int DIV0 = dgct_pkg::DIV_SCALE0,
  parameter int DIV1 = dgct_pkg::DIV_SCALE1,
  parameter int DIV2 = dgct_pkg::DIV_SCALE2,
  parameter int DIV3 = dgct_pkg::DIV_EXT
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // selection and sources
  input  wire logic [1:0] prescale_select_field,
  input  wire logic       ext_osc_tick,
  // tick out
  output logic            presc_tick
);

  logic [7:0] div_cnt_reg;
  logic [1:0] scale_prev_reg;
  logic       presc_tick_reg;
  wire  [7:0] div_last = (prescale_select_field == 2'b00) ? 8'(DIV0 - 1) :
                         (prescale_select_field == 2'b01) ? 8'(DIV1 - 1) :
                         (prescale_select_field == 2'b10) ? 8'(DIV2 - 1) : 8'(DIV3 - 1);
  wire        src_step = (prescale_select_field == 2'b11) ? ext_osc_tick : 1'b1;
  wire        restart  = (scale_prev_reg != prescale_select_field);
  wire        wrap     = src_step && (div_cnt_reg >= div_last);

  // divider restarts whenever the scale changes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_reg    <= 8'h00;
      scale_prev_reg <= 2'b00;
      presc_tick_reg <= 1'b0;
    end else begin
      scale_prev_reg <= prescale_select_field;
      presc_tick_reg <= wrap && !restart;
      if (restart || wrap) begin
        div_cnt_reg <= 8'h00;
      end else if (src_step) begin
        div_cnt_reg <= div_cnt_reg + 8'h01;
      end
    end
  end

  assign presc_tick = presc_tick_reg;

endmodule

// *** dgct_timer_unit.sv ***
// dgct_timer_unit: one counter/timer, count bytes and source choice.
// assumes: enable, gating and pins already synchronous to sys_clk.
module dgct_timer_unit (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // configuration
  input  wire logic [1:0] mode,
  input  wire logic       count_source_select,
  input  wire logic       sysclk_select,
  input  wire logic       count_enable,
  // count sources
  input  wire logic       presc_tick,
  input  wire logic       event_pin,
  // byte writes
  input  wire logic       wr_low,
  input  wire logic       wr_high,
  input  wire logic [7:0] wr_data,
  // state
  output logic [7:0]      low_byte,
  output logic [7:0]      high_byte,
  output logic            overflow
);

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic        pin_reg;
  logic        pin_prev_reg;

  // falling edge of the sampled event pin
  wire event_fall = pin_prev_reg && !pin_reg;
  wire tick       = count_source_select ? event_fall :
                    (sysclk_select ? 1'b1 : presc_tick);
  wire mode_ok    = (mode == dgct_pkg::DGCT_MODE_13BIT) || (mode == dgct_pkg::DGCT_MODE_16BIT);
  wire step       = count_enable && tick && mode_ok;

  // next count: byte writes win over a step in the same cycle
  always_comb begin
    count_next = count_reg;
    if (wr_low) begin
      count_next = {count_reg[15:8], wr_data};
    end else if (wr_high) begin
      count_next = {wr_data, count_reg[7:0]};
    end else if (step) begin
      count_next = dgct_pkg::next_count(mode, count_reg);
    end
  end

  // count register and event pin sampling
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg    <= dgct_pkg::RESET_COUNT;
      pin_reg      <= 1'b1;
      pin_prev_reg <= 1'b1;
    end else begin
      count_reg    <= count_next;
      pin_reg      <= event_pin;
      pin_prev_reg <= pin_reg;
    end
  end

  assign overflow  = step && !wr_low && !wr_high && dgct_pkg::at_top(mode, count_reg);
  assign low_byte  = count_reg[7:0];
  assign high_byte = count_reg[15:8];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_event_step: assert property (
    count_source_select && count_enable && event_fall && !wr_low && !wr_high && mode_ok
    |=> count_reg == dgct_pkg::next_count($past(mode), $past(count_reg)))
    else $error("event edge did not advance count");
  a_sysclk_step: assert property (
    !count_source_select && sysclk_select && count_enable && !wr_low && !wr_high && mode_ok
    |=> count_reg == dgct_pkg::next_count($past(mode), $past(count_reg)))
    else $error("system clock step missing");
  a_mode_hold: assert property (
    !mode_ok && !wr_low && !wr_high |=> $stable(count_reg))
    else $error("count moved in an unsupported mode");
  c_event_step: cover property (count_source_select && count_enable && event_fall);

endmodule

// *** dgct_pin_model.sv ***
// dgct_pin_model: far side of the timers, event and gate pins.
// assumes: called from the bench thread, pins change right after sys_clk rises.
module dgct_pin_model (
  // clock
  input  wire logic sys_clk,
  // pins towards the timers
  output logic      event_pin_a,
  output logic      event_pin_b,
  output logic      gate_input_a,
  output logic      gate_input_b
);
  timeunit 1ns;
  timeprecision 1ps;

  // event pins idle high so no false falling edge at start
  initial begin
    event_pin_a  = 1'b1;
    event_pin_b  = 1'b1;
    gate_input_a = 1'b0;
    gate_input_b = 1'b0;
  end

  // n falling edges, each level held hold cycles, never fewer than two
  task automatic pulses(input int t, input int n, input int hold);
    int h;
    h = (hold < 2) ? 2 : hold;
    repeat (n) begin
      @(posedge sys_clk);
      if (t == 0) event_pin_a <= 1'b0; else event_pin_b <= 1'b0;
      repeat (h) @(posedge sys_clk);
      if (t == 0) event_pin_a <= 1'b1; else event_pin_b <= 1'b1;
      repeat (h - 1) @(posedge sys_clk);
    end
  endtask

  // steady gate level for one timer
  task automatic set_gate(input int t, input logic v);
    @(posedge sys_clk);
    if (t == 0) gate_input_a <= v; else gate_input_b <= v;
  endtask
endmodule

// *** testbench.sv ***
// testbench: apb driver with expectation queue and output monitor.
// assumes: zero wait apb slave, counting on every enabled sys_clk edge when the sys_clk source is selected.
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset, apb and side inputs
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdq;
  logic        pready, pslverr, ext_osc_tick = 1'b0;
  logic        ev_a, ev_b, gt_a, gt_b;
  logic [1:0]  irq_req, ack = 2'b00;
  logic [64:0] exp_q[$];
  logic [64:0] note;
  logic [31:0] seed = 32'd80;
  int          errors = 0, checks_done = 0, cnt, ex, dv;
  int          run_b[2] = '{dgct_pkg::BIT_RUN_A, dgct_pkg::BIT_RUN_B};
  int          flg_b[2] = '{dgct_pkg::BIT_FLAG_A, dgct_pkg::BIT_FLAG_B};
  int          sys_b[2] = '{dgct_pkg::BIT_SYSCLK_A, dgct_pkg::BIT_SYSCLK_B};
  int          pol_b[2] = '{dgct_pkg::BIT_POL_A, dgct_pkg::BIT_POL_B};
  int          ien_b[2] = '{dgct_pkg::BIT_IRQ_EN_A, dgct_pkg::BIT_IRQ_EN_B};
  logic [7:0]  lo_o[2] = '{dgct_pkg::OFS_A_LOW, dgct_pkg::OFS_B_LOW};
  logic [7:0]  hi_o[2] = '{dgct_pkg::OFS_A_HIGH, dgct_pkg::OFS_B_HIGH};

  // clock and free running external tick pulses
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) ext_osc_tick <= ~ext_osc_tick;

  dgct_top #(.DIV0(3), .DIV1(2), .DIV2(5), .DIV3(2)) DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_pin_a(ev_a), .event_pin_b(ev_b),
    .gate_input_a(gt_a), .gate_input_b(gt_b), .ext_osc_tick(ext_osc_tick),
    .irq_req_a(irq_req[0]), .irq_req_b(irq_req[1]), .irq_ack_a(ack[0]),
    .irq_ack_b(ack[1]));
  dgct_pin_model pins (.sys_clk(sys_clk), .event_pin_a(ev_a), .event_pin_b(ev_b),
    .gate_input_a(gt_a), .gate_input_b(gt_b));

  // xorshift source of random stimulus
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // one apb transfer; the expectation is queued in the setup cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    exp_q.push_back({a > dgct_pkg::OFS_B_HIGH, w ? 32'h0 : d, w ? 32'h0 : m});
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdq = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0);
  endtask

  // count bytes loaded before the run bit is set
  task automatic load(input int t, input logic [7:0] h, input logic [7:0] l);
    wr(hi_o[t], {24'h0, h});
    wr(lo_o[t], {24'h0, l});
  endtask

  // run for n idle cycles between the two writes: n+3 counting edges
  task automatic run_for(input int t, input int n);
    wr(dgct_pkg::OFS_CONTROL, 32'h1 << run_b[t]);
    repeat (n) @(posedge sys_clk);
    wr(dgct_pkg::OFS_CONTROL, 32'h0);
  endtask

  // monitor: every completed access is checked against the oldest note
  always @(posedge sys_clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      note = exp_q.pop_front();
      `CHK(pslverr, note[64])
      `CHK(prdata & note[31:0], note[63:32] & note[31:0])
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    // reset values of the whole map, then one unmapped address
    for (int i = 0; i <= 9; i++) apb(1'b0, 8'(4 * i), 32'h0, 32'hffffffff);
    $display("test reset done");
    for (int t = 0; t < 2; t++) begin
      // rollover at the very edge of a clearing control write
      wr(dgct_pkg::OFS_MODE, 32'h0);
      wr(dgct_pkg::OFS_CLOCK, 32'h1 << sys_b[t]);
      load(t, 8'hff, (8'(xs()) & 8'he0) | 8'h1d);
      run_for(t, 0);
      apb(1'b0, hi_o[t], 32'h0, 32'hff);
      apb(1'b0, lo_o[t], 32'h0, 32'h1f);
      apb(1'b0, dgct_pkg::OFS_CONTROL, 32'h1 << flg_b[t], 32'hff);
      @(negedge sys_clk);
      `CHK(irq_req[t], 1'b0)
      wr(dgct_pkg::OFS_IRQ_EN, 32'h1 << ien_b[t]);
      repeat (3) @(negedge sys_clk);
      `CHK(irq_req[t], 1'b1)
      if (t == 0) begin
        @(posedge sys_clk) ack[t] <= 1'b1;
        @(posedge sys_clk) ack[t] <= 1'b0;
      end else wr(dgct_pkg::OFS_CONTROL, 32'h0);
      @(negedge sys_clk);
      `CHK(irq_req[t], 1'b0)
      wr(dgct_pkg::OFS_IRQ_EN, 32'h0);
      // falling edges on the event pin, fast and slow holds
      wr(dgct_pkg::OFS_MODE, 32'h4 << (4 * t));
      load(t, 8'h00, 8'h00);
      cnt = 1 + int'(xs() % 8);
      wr(dgct_pkg::OFS_CONTROL, 32'h1 << run_b[t]);
      pins.pulses(t, cnt, 2 + t);
      repeat (4) @(posedge sys_clk);
      wr(dgct_pkg::OFS_CONTROL, 32'h0);
      apb(1'b0, lo_o[t], 32'(cnt), 32'h1f);
      // gate: inactive level holds, active low then active high counts
      wr(dgct_pkg::OFS_MODE, 32'h8 << (4 * t));
      wr(dgct_pkg::OFS_CLOCK, 32'h1 << sys_b[t]);
      wr(dgct_pkg::OFS_EXTCFG, 32'h1 << pol_b[t]);
      pins.set_gate(t, 1'b0);
      load(t, 8'h00, 8'h00);
      run_for(t, 5);
      apb(1'b0, lo_o[t], 32'h0, 32'h1f);
      wr(dgct_pkg::OFS_EXTCFG, 32'h0);
      run_for(t, 5);
      apb(1'b0, lo_o[t], 32'h8, 32'h1f);
      wr(dgct_pkg::OFS_EXTCFG, 32'h1 << pol_b[t]);
      pins.set_gate(t, 1'b1);
      run_for(t, 5);
      apb(1'b0, lo_o[t], 32'h10, 32'h1f);
      $display("test timer %0d done", t);
    end
    // prescaled sources, phase unknown so one tick either way
    wr(dgct_pkg::OFS_MODE, 32'h0);
    for (int s = 0; s < 4; s++) begin
      dv = (s == 0) ? 3 : (s == 1) ? 2 : (s == 2) ? 5 : 4;
      wr(dgct_pkg::OFS_CLOCK, 32'(s));
      load(0, 8'h00, 8'h00);
      run_for(0, 40);
      apb(1'b0, dgct_pkg::OFS_A_LOW, 32'h0, 32'h0);
      ex = 43 / dv;
      `CHK((rdq[4:0] >= ex - 1) && (rdq[4:0] <= ex + 1), 1'b1)
    end
    $display("test prescale done");
    // full sixteen bit count on timer a, then a mode that must hold
    wr(dgct_pkg::OFS_CLOCK, (32'h1 << sys_b[0]) | (32'h1 << sys_b[1]));
    wr(dgct_pkg::OFS_MODE, 32'h1);
    load(0, 8'h00, 8'hfe);
    run_for(0, 0);
    apb(1'b0, dgct_pkg::OFS_A_LOW, 32'h01, 32'hff);
    apb(1'b0, dgct_pkg::OFS_A_HIGH, 32'h01, 32'hff);
    wr(dgct_pkg::OFS_MODE, 32'h2);
    run_for(0, 5);
    apb(1'b0, dgct_pkg::OFS_A_LOW, 32'h01, 32'hff);
    // timer b rollover between bus writes with its interrupt enabled
    wr(dgct_pkg::OFS_IRQ_EN, 32'h1 << ien_b[1]);
    load(1, 8'hff, 8'h1d);
    run_for(1, 1);
    apb(1'b0, dgct_pkg::OFS_B_LOW, 32'h01, 32'h1f);
    apb(1'b0, dgct_pkg::OFS_B_HIGH, 32'h00, 32'hff);
    $display("test modes done");
    close_out();
  end
endmodule
